// ==== core/pts_pkg.sv ====
package pts_pkg;
   localparam int          PADDR_W        = 8;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;
   localparam logic [7:0]  OFS_STAT       = 8'h04;
   localparam logic [7:0]  OFS_INP_RANGE  = 8'h08;
   localparam logic [7:0]  OFS_ROUGH      = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_STAT   = 8'h10;
   localparam logic [7:0]  OFS_IRQ_MASK   = 8'h14;
   localparam logic [7:0]  OFS_STG_POS    = 8'h20;
   localparam logic [7:0]  OFS_STG_SPDACC = 8'h24;
   localparam logic [7:0]  OFS_STG_DECDWL = 8'h28;
   localparam logic [7:0]  OFS_STG_AUX    = 8'h2C;
   localparam logic [7:0]  OFS_TBL_WR     = 8'h30;
   localparam int          CTRL_START_BIT = 0;
   localparam int          CTRL_IDX_LSB   = 8;
   localparam int          ST_INP_BIT     = 0;
   localparam int          ST_ROUGH_BIT   = 1;
   localparam int          ST_MEND_BIT    = 2;
   localparam int          ST_BUSY_BIT    = 3;
   localparam int          ST_IDX_LSB     = 8;
   localparam int          AUX_MC_LSB     = 8;
   localparam int          IRQ_W          = 3;
   localparam int          IRQ_MEND_BIT   = 0;
   localparam int          IRQ_STEP_BIT   = 1;
   localparam int          IRQ_REJ_BIT    = 2;
   localparam logic [31:0] INP_RANGE_RST  = 32'h0000_0064;
   localparam logic [31:0] ROUGH_RST      = 32'h0000_0000;
   localparam logic [3:0]  AUX_ABS_END    = 4'h0;
   localparam logic [3:0]  AUX_ABS_CHN    = 4'h1;
   localparam logic [3:0]  AUX_REL_END    = 4'h2;
   localparam logic [3:0]  AUX_REL_CHN    = 4'h3;
   localparam logic [3:0]  AUX_REP_ABS    = 4'h8;
   localparam logic [3:0]  AUX_REP_ABS1   = 4'h9;
   localparam logic [3:0]  AUX_REP_REL    = 4'hA;
   localparam logic [3:0]  AUX_REP_REL1   = 4'hB;
   localparam logic [7:0]  FIRST_ENTRY    = 8'h01;
   localparam logic [7:0]  LAST_ENTRY     = 8'hFF;
   localparam int          DWELL_UNIT_NS  = 1000000;
   localparam int          CLK_NS         = 25;
   localparam int          DWELL_UNIT_CYC = DWELL_UNIT_NS / CLK_NS;

   typedef struct packed {
      logic [31:0] pos;
      logic [15:0] spd;
      logic [15:0] acc;
      logic [15:0] dec;
      logic [15:0] dwell;
      logic [3:0]  aux;
      logic [7:0]  mcode;
   } pts_entry_s;

   typedef enum logic [2:0] {PTS_IDLE, PTS_LOAD, PTS_ISSUE, PTS_RUN, PTS_SETTLE, PTS_DWELL} pts_state_e;

   function automatic logic pts_aux_chain(input logic [3:0] aux);
      return (aux == AUX_ABS_CHN) || (aux == AUX_REL_CHN);
   endfunction : pts_aux_chain

   function automatic logic pts_aux_rep_start(input logic [3:0] aux);
      return (aux == AUX_REP_ABS) || (aux == AUX_REP_REL);
   endfunction : pts_aux_rep_start

   function automatic logic pts_aux_rep_one(input logic [3:0] aux);
      return (aux == AUX_REP_ABS1) || (aux == AUX_REP_REL1);
   endfunction : pts_aux_rep_one

   function automatic logic pts_aux_rel(input logic [3:0] aux);
      return (aux == AUX_REL_END) || (aux == AUX_REL_CHN) || (aux == AUX_REP_REL) || (aux == AUX_REP_REL1);
   endfunction : pts_aux_rel
endpackage : pts_pkg

// ==== core/pts_tbl_mem.sv ====
`timescale 1ns/1ps
module pts_tbl_mem #(
   parameter int AW = 8,
   parameter int DW = 108
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata_ff
);
   // No reset on the array; contents are undefined until written
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= mem[raddr];
      end
   end
endmodule : pts_tbl_mem

// ==== core/pts_flags.sv ====
`timescale 1ns/1ps
module pts_flags (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [31:0] follow_err,
   input  wire logic [31:0] remain_dist,
   input  wire logic [31:0] inp_range,
   input  wire logic [31:0] rough_range,
   input  wire logic        chain_op,
   output logic             in_position_flag,
   output logic             rough_match_flag,
   output logic             travel_complete_flag
);
   logic nxt_inp;
   logic nxt_rough;
   logic nxt_mend;

   always_comb begin
      nxt_inp   = (follow_err <= inp_range);
      nxt_rough = (remain_dist <= rough_range) && !chain_op;
      nxt_mend  = nxt_inp && (remain_dist == 32'h0000_0000) && !chain_op;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_position_flag     <= 1'b0;
         rough_match_flag     <= 1'b0;
         travel_complete_flag <= 1'b0;
      end else begin
         in_position_flag     <= nxt_inp;
         rough_match_flag     <= nxt_rough;
         travel_complete_flag <= nxt_mend;
      end
   end
endmodule : pts_flags

// ==== core/pts_sequencer.sv ====
// Function
// - Codes 1/3 switch to next speed, no stop; this design does so only at zero dwell, else it settles and dwells first
// - Chaining allowed up to entry 254
// - End code 0 absolute, 2 relative
// - Code one or three continues into next entry
// - Each stage applies its own speed, times
// - In-position when following error within range
// - Rough match within range, off when chaining
// - Travel complete: in-position and zero remaining
// - Codes 8/10 repeat from start entry
// - Codes 9/11 repeat from entry one
// - Chain code 1 absolute, 3 relative
// - Start ignored while motor moving
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module pts_sequencer
   import pts_pkg::*;
#(
   parameter int DWELL_CYC = DWELL_UNIT_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               motor_moving,
   input  wire logic               seg_done,
   input  wire logic [31:0]        follow_err,
   input  wire logic [31:0]        remain_dist,
   output logic                    seg_load,
   output logic                    seg_speed_change,
   output logic                    seg_relative,
   output logic      [31:0]        seg_target,
   output logic      [15:0]        seg_speed,
   output logic      [15:0]        seg_acc,
   output logic      [15:0]        seg_dec,
   output logic      [7:0]         seg_mcode,
   output logic      [7:0]         seg_entry,
   output logic                    in_position_flag,
   output logic                    rough_match_flag,
   output logic                    travel_complete_flag,
   output logic                    irq
);
   localparam int EW = $bits(pts_entry_s);

   // Register group
   logic [31:0]      in_position_range_param_ff, nxt_inp_range;
   logic [31:0]      rough_match_range_ff, nxt_rough_range;
   logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
   logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
   logic [31:0]      stg_pos_ff, nxt_stg_pos;
   logic [31:0]      stg_spdacc_ff, nxt_stg_spdacc;
   logic [31:0]      stg_decdwl_ff, nxt_stg_decdwl;
   logic [15:0]      stg_aux_ff, nxt_stg_aux;
   logic [31:0]      prdata_ff, nxt_prdata;
   logic             pslverr_ff, nxt_pslverr;
   logic             mend_d_ff;
   logic             wr_acc;
   logic             setup;
   logic             start_req;
   logic             tbl_we;
   logic [7:0]       tbl_waddr;
   pts_entry_s       tbl_wdata;
   logic [EW-1:0]    tbl_rdata;
   logic [IRQ_W-1:0] irq_ev;
   logic             mapped;

   // Sequencer group
   pts_state_e       state_ff, nxt_state;
   logic [7:0]       idx_ff, nxt_idx;
   logic [7:0]       start_idx_ff, nxt_start_idx;
   pts_entry_s       ent_ff, nxt_ent;
   logic             load_ff, nxt_load;
   logic             chg_ff, nxt_chg;
   logic             rel_ff, nxt_rel;
   logic [15:0]      cyc_ff, nxt_cyc;
   logic [15:0]      ms_ff, nxt_ms;
   logic             rej;
   logic             chain_op;
   logic             last_here;

   assign setup     = psel && !penable;
   assign wr_acc    = psel && penable && pwrite;
   assign start_req = wr_acc && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT];
   assign tbl_we    = wr_acc && (paddr == OFS_TBL_WR);
   assign tbl_waddr = pwdata[7:0];
   assign tbl_wdata = '{pos: stg_pos_ff, spd: stg_spdacc_ff[15:0], acc: stg_spdacc_ff[31:16],
                        dec: stg_decdwl_ff[15:0], dwell: stg_decdwl_ff[31:16],
                        aux: stg_aux_ff[3:0], mcode: stg_aux_ff[AUX_MC_LSB +: 8]};
   // Zero-wait slave; read data is staged in the setup cycle
   assign pready    = 1'b1;
   assign prdata    = prdata_ff;
   assign pslverr   = pslverr_ff;

   always_comb begin
      case (paddr)
         OFS_CTRL, OFS_STAT, OFS_INP_RANGE, OFS_ROUGH, OFS_IRQ_STAT, OFS_IRQ_MASK,
         OFS_STG_POS, OFS_STG_SPDACC, OFS_STG_DECDWL, OFS_STG_AUX, OFS_TBL_WR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      nxt_inp_range   = in_position_range_param_ff;
      nxt_rough_range = rough_match_range_ff;
      nxt_irq_mask    = irq_mask_ff;
      nxt_stg_pos     = stg_pos_ff;
      nxt_stg_spdacc  = stg_spdacc_ff;
      nxt_stg_decdwl  = stg_decdwl_ff;
      nxt_stg_aux     = stg_aux_ff;
      nxt_prdata      = prdata_ff;
      nxt_pslverr     = pslverr_ff;
      irq_ev          = '0;
      irq_ev[IRQ_MEND_BIT] = travel_complete_flag && !mend_d_ff;
      irq_ev[IRQ_STEP_BIT] = load_ff;
      irq_ev[IRQ_REJ_BIT]  = rej;
      nxt_irq_stat    = irq_stat_ff;
      if (wr_acc) begin
         case (paddr)
            OFS_INP_RANGE:  nxt_inp_range = pwdata;
            OFS_ROUGH:      nxt_rough_range = pwdata;
            OFS_IRQ_STAT:   nxt_irq_stat = irq_stat_ff & ~pwdata[IRQ_W-1:0];
            OFS_IRQ_MASK:   nxt_irq_mask = pwdata[IRQ_W-1:0];
            OFS_STG_POS:    nxt_stg_pos = pwdata;
            OFS_STG_SPDACC: nxt_stg_spdacc = pwdata;
            OFS_STG_DECDWL: nxt_stg_decdwl = pwdata;
            OFS_STG_AUX:    nxt_stg_aux = pwdata[15:0];
            default: ;
         endcase
      end
      // Set beats clear so no event is lost
      nxt_irq_stat = nxt_irq_stat | irq_ev;
      if (setup) begin
         nxt_pslverr = !mapped;
         nxt_prdata  = 32'h0000_0000;
         case (paddr)
            OFS_CTRL:       nxt_prdata[CTRL_IDX_LSB +: 8] = start_idx_ff;
            OFS_STAT: begin
               nxt_prdata[ST_INP_BIT]       = in_position_flag;
               nxt_prdata[ST_ROUGH_BIT]     = rough_match_flag;
               nxt_prdata[ST_MEND_BIT]      = travel_complete_flag;
               nxt_prdata[ST_BUSY_BIT]      = (state_ff != PTS_IDLE);
               nxt_prdata[ST_IDX_LSB +: 8]  = idx_ff;
            end
            OFS_INP_RANGE:  nxt_prdata = in_position_range_param_ff;
            OFS_ROUGH:      nxt_prdata = rough_match_range_ff;
            OFS_IRQ_STAT:   nxt_prdata[IRQ_W-1:0] = irq_stat_ff;
            OFS_IRQ_MASK:   nxt_prdata[IRQ_W-1:0] = irq_mask_ff;
            OFS_STG_POS:    nxt_prdata = stg_pos_ff;
            OFS_STG_SPDACC: nxt_prdata = stg_spdacc_ff;
            OFS_STG_DECDWL: nxt_prdata = stg_decdwl_ff;
            OFS_STG_AUX:    nxt_prdata[15:0] = stg_aux_ff;
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_position_range_param_ff <= INP_RANGE_RST;
         rough_match_range_ff       <= ROUGH_RST;
         irq_stat_ff                <= '0;
         irq_mask_ff                <= '0;
         stg_pos_ff                 <= '0;
         stg_spdacc_ff              <= '0;
         stg_decdwl_ff              <= '0;
         stg_aux_ff                 <= '0;
         prdata_ff                  <= '0;
         pslverr_ff                 <= 1'b0;
         mend_d_ff                  <= 1'b0;
      end else begin
         in_position_range_param_ff <= nxt_inp_range;
         rough_match_range_ff       <= nxt_rough_range;
         irq_stat_ff                <= nxt_irq_stat;
         irq_mask_ff                <= nxt_irq_mask;
         stg_pos_ff                 <= nxt_stg_pos;
         stg_spdacc_ff              <= nxt_stg_spdacc;
         stg_decdwl_ff              <= nxt_stg_decdwl;
         stg_aux_ff                 <= nxt_stg_aux;
         prdata_ff                  <= nxt_prdata;
         pslverr_ff                 <= nxt_pslverr;
         mend_d_ff                  <= travel_complete_flag;
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   pts_tbl_mem #(
      .AW (8),
      .DW (EW)
   ) u_mem (
      .pclk     (pclk),
      .presetn  (presetn),
      .we       (tbl_we),
      .waddr    (tbl_waddr),
      .wdata    (tbl_wdata),
      .raddr    (idx_ff),
      .rdata_ff (tbl_rdata)
   );

   // Rough and travel-complete flags stay quiet while busy except in RUN or SETTLE of an entry with no chain or repeat code
   assign chain_op  = (state_ff != PTS_IDLE) &&
                      !(!pts_aux_chain(ent_ff.aux) && !pts_aux_rep_start(ent_ff.aux) &&
                        !pts_aux_rep_one(ent_ff.aux) && (state_ff inside {PTS_RUN, PTS_SETTLE}));
   // Entry 255 cannot chain further, so a chain code there ends the move
   assign last_here = (idx_ff == LAST_ENTRY);

   pts_flags u_flags (
      .pclk                 (pclk),
      .presetn              (presetn),
      .follow_err           (follow_err),
      .remain_dist          (remain_dist),
      .inp_range            (in_position_range_param_ff),
      .rough_range          (rough_match_range_ff),
      .chain_op             (chain_op),
      .in_position_flag     (in_position_flag),
      .rough_match_flag     (rough_match_flag),
      .travel_complete_flag (travel_complete_flag)
   );

   always_comb begin
      nxt_state     = state_ff;
      nxt_idx       = idx_ff;
      nxt_start_idx = start_idx_ff;
      nxt_ent       = ent_ff;
      nxt_load      = 1'b0;
      nxt_chg       = chg_ff;
      nxt_rel       = rel_ff;
      nxt_cyc       = cyc_ff;
      nxt_ms        = ms_ff;
      rej           = 1'b0;
      case (state_ff)
         PTS_IDLE: begin
            if (start_req) begin
               if (motor_moving) begin
                  rej = 1'b1;
               end else begin
                  nxt_start_idx = pwdata[CTRL_IDX_LSB +: 8];
                  nxt_idx       = pwdata[CTRL_IDX_LSB +: 8];
                  nxt_chg       = 1'b0;
                  nxt_state     = PTS_LOAD;
               end
            end
         end
         PTS_LOAD: nxt_state = PTS_ISSUE;
         PTS_ISSUE: begin
            nxt_ent   = pts_entry_s'(tbl_rdata);
            nxt_rel   = pts_aux_rel(tbl_rdata[11:8]);
            nxt_load  = 1'b1;
            nxt_state = PTS_RUN;
         end
         PTS_RUN: begin
            if (seg_done) begin
               if (pts_aux_chain(ent_ff.aux) && (ent_ff.dwell == 16'h0000) && !last_here) begin
                  nxt_idx   = idx_ff + 8'h01;
                  nxt_chg   = 1'b1;
                  nxt_state = PTS_LOAD;
               end else begin
                  nxt_state = PTS_SETTLE;
               end
            end
         end
         PTS_SETTLE: begin
            if (in_position_flag) begin
               nxt_cyc = '0;
               nxt_ms  = '0;
               if ((!pts_aux_chain(ent_ff.aux) && !pts_aux_rep_start(ent_ff.aux) &&
                    !pts_aux_rep_one(ent_ff.aux)) || (pts_aux_chain(ent_ff.aux) && last_here)) begin
                  nxt_state = PTS_IDLE;
               end else begin
                  nxt_state = PTS_DWELL;
               end
            end
         end
         PTS_DWELL: begin
            if (ms_ff >= ent_ff.dwell) begin
               nxt_chg   = 1'b0;
               nxt_state = PTS_LOAD;
               if (pts_aux_rep_start(ent_ff.aux)) begin
                  nxt_idx = start_idx_ff;
               end else if (pts_aux_rep_one(ent_ff.aux)) begin
                  nxt_idx = FIRST_ENTRY;
               end else begin
                  nxt_idx = idx_ff + 8'h01;
               end
            end else if (cyc_ff == 16'(DWELL_CYC - 1)) begin
               nxt_cyc = '0;
               nxt_ms  = ms_ff + 16'h0001;
            end else begin
               nxt_cyc = cyc_ff + 16'h0001;
            end
         end
         default: nxt_state = PTS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff     <= PTS_IDLE;
         idx_ff       <= FIRST_ENTRY;
         start_idx_ff <= FIRST_ENTRY;
         ent_ff       <= '0;
         load_ff      <= 1'b0;
         chg_ff       <= 1'b0;
         rel_ff       <= 1'b0;
         cyc_ff       <= '0;
         ms_ff        <= '0;
      end else begin
         state_ff     <= nxt_state;
         idx_ff       <= nxt_idx;
         start_idx_ff <= nxt_start_idx;
         ent_ff       <= nxt_ent;
         load_ff      <= nxt_load;
         chg_ff       <= nxt_chg;
         rel_ff       <= nxt_rel;
         cyc_ff       <= nxt_cyc;
         ms_ff        <= nxt_ms;
      end
   end

   assign seg_load         = load_ff;
   assign seg_speed_change = chg_ff;
   assign seg_relative     = rel_ff;
   assign seg_target       = ent_ff.pos;
   assign seg_speed        = ent_ff.spd;
   assign seg_acc          = ent_ff.acc;
   assign seg_dec          = ent_ff.dec;
   assign seg_mcode        = ent_ff.mcode;
   assign seg_entry        = idx_ff;
endmodule : pts_sequencer

// ==== dv/pts_properties.sv ====
`timescale 1ns/1ps
module pts_properties
   import pts_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [7:0]   paddr,
   input wire logic [31:0]  pwdata,
   input wire logic         pslverr,
   input wire logic         motor_moving,
   input wire logic         seg_done,
   input wire logic [31:0]  follow_err,
   input wire logic [31:0]  remain_dist,
   input wire logic         seg_load,
   input wire logic         seg_speed_change,
   input wire logic [31:0]  seg_target,
   input wire logic [7:0]   seg_entry,
   input wire logic         in_position_flag,
   input wire logic         travel_complete_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic start_acc;
   assign start_acc = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];

   AST_LOAD_PULSE: assert property (seg_load |=> !seg_load)
      else $error("seg_load wider than one cycle");
   AST_SEG_HOLD: assert property (!seg_load |-> $stable(seg_target))
      else $error("segment data moved without a load");
   // Index leads the load pulse by the table fetch
   AST_ENTRY_LEAD: assert property ($changed(seg_entry) |-> ##2 seg_load)
      else $error("entry index moved without a load");
   AST_INP: assert property ($past(presetn) && $past(follow_err) == 32'h0 |-> in_position_flag)
      else $error("in-position low at zero error");
   AST_MEND: assert property (travel_complete_flag |-> $past(remain_dist) == 32'h0 && in_position_flag)
      else $error("travel complete without cause");
   // Holds only while no segment can end within the window
   AST_START_REJ: assert property (start_acc && motor_moving |=> !seg_load [*3])
      else $error("start taken while moving");
   AST_SPDCHG: assert property (seg_load && seg_speed_change |-> $past(seg_done, 3))
      else $error("on-the-fly load not tied to segment end");
   AST_STEP: assert property (seg_load && seg_speed_change |-> seg_entry == $past(seg_entry, 3) + 8'h01)
      else $error("chained entry not next index");
   AST_SLVERR: assert property (psel && !penable && paddr == 8'hFC |=> pslverr)
      else $error("no error for unmapped address");
endmodule : pts_properties

// ==== dv/pts_motion_model.sv ====
`timescale 1ns/1ps
module pts_motion_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        seg_load,
   output logic             motor_moving,
   output logic             seg_done,
   output logic      [31:0] follow_err,
   output logic      [31:0] remain_dist
);
   // Fixed segment; command ends halfway, then the motor settles
   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   always_comb begin
      nxt_cnt = cnt_ff;
      if (seg_load) nxt_cnt = 5'h1F;
      else if (cnt_ff != 5'h00) nxt_cnt = cnt_ff - 5'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_ff <= 5'h00;
      else cnt_ff <= nxt_cnt;
   end
   assign motor_moving = cnt_ff != 5'h00;
   assign seg_done     = cnt_ff == 5'h10;
   // Error above the default range while moving
   assign follow_err   = motor_moving ? 32'h0000_01F4 : 32'h0000_0000;
   assign remain_dist  = (cnt_ff > 5'h10) ? {27'h0, cnt_ff - 5'h10} * 32'h0000_000A : 32'h0000_0000;
endmodule : pts_motion_model

// ==== dv/tb_pts_sequencer.sv ====
`timescale 1ns/1ps
module tb_pts_sequencer
   import pts_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, slv, irq;
   logic        motor_moving, seg_done, seg_load, seg_speed_change, seg_relative;
   logic        in_position_flag, rough_match_flag, travel_complete_flag;
   logic [7:0]  paddr, seg_mcode, seg_entry;
   logic [31:0] pwdata, prdata, follow_err, remain_dist, seg_target;
   logic [15:0] seg_speed, seg_acc, seg_dec;
   logic [3:0]  t_aux [256];
   logic [15:0] t_dw [256];
   int          err_total, checked;
   int          lst [10] = '{1, 2, 3, 4, 5, 7, 8, 10, 254, 255};

   always #12.5 pclk = ~pclk;

   pts_sequencer #(.DWELL_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .motor_moving, .seg_done, .follow_err, .remain_dist, .seg_load, .seg_speed_change,
      .seg_relative, .seg_target, .seg_speed, .seg_acc, .seg_dec, .seg_mcode, .seg_entry, .in_position_flag,
      .rough_match_flag, .travel_complete_flag, .irq);
   pts_motion_model mdl (.pclk, .presetn, .seg_load, .motor_moving, .seg_done, .follow_err, .remain_dist);

   task print_verdict;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_total++;
      if (n >= 50) print_verdict();
      q = prdata;
      slv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk($sformatf("reg %0h", a), e, q & m);
   endtask : rd

   task put(input int i);
      logic [7:0] e;
      e = 8'(i);
      wr(OFS_STG_POS, {16'h0, 8'h10, e});
      wr(OFS_STG_SPDACC, {8'h02, e, 8'h01, e});
      wr(OFS_STG_DECDWL, {t_dw[e], 8'h03, e});
      wr(OFS_STG_AUX, {16'h0, e, 4'h0, t_aux[e]});
      wr(OFS_TBL_WR, {24'h0, e});
   endtask : put

   task expect_load(input logic [7:0] e, input logic sc);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (seg_load !== 1'b1 && n < 500);
      chk("seg_load", 1'b1, seg_load);
      if (seg_load !== 1'b1) print_verdict();
      chk("seg_entry", e, seg_entry);
      chk("seg_speed_change", sc, seg_speed_change);
      chk("seg_relative", t_aux[e][1], seg_relative);
      chk("seg_fields", {16'h10, e, 8'h01, e, 8'h02, e, 8'h03, e, e},
          {seg_target, seg_speed, seg_acc, seg_dec, seg_mcode});
      if (sc && t_aux[e][0] && !t_aux[e][3]) chk("rough_match_flag", 1'b0, rough_match_flag);
   endtask : expect_load

   task run(input logic [7:0] s, input int nl, input logic rej);
      logic [7:0] e;
      logic [3:0] a;
      logic       sc;
      e = s;
      sc = 1'b0;
      wr(OFS_CTRL, {16'h0, s, 8'h01});
      for (int k = 0; k < nl; k++) begin
         expect_load(e, sc);
         if (rej && k == 0) wr(OFS_CTRL, 32'h0000_0101);
         if (rej && k == 0) rd(OFS_IRQ_STAT, 32'h0, 32'h4);
         if (rej && k == 0) chk("irq", 1'b0, irq);
         a = t_aux[e];
         sc = (a == 4'h1 || a == 4'h3) && t_dw[e] == 16'h0 && e != 8'hFF;
         // Repeat codes go back to the start entry or to entry one
         e = (a == 4'h1 || a == 4'h3) ? e + 8'h01 : a[3] ? (a[0] ? 8'h01 : s) : e;
      end
   endtask : run

   task finish_run(input logic [7:0] e);
      logic [31:0] q;
      int          n;
      n = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0, q);
         n++;
      end while (q[ST_BUSY_BIT] !== 1'b0 && n < 50);
      if (q[ST_BUSY_BIT] !== 1'b0) err_total++;
      if (q[ST_BUSY_BIT] !== 1'b0) print_verdict();
      // Flags trail the idle state by one cycle
      apb(1'b0, OFS_STAT, 32'h0, q);
      chk("stat", {16'h0, e, 8'h07}, q);
   endtask : finish_run

   task do_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (lst[i]) put(lst[i]);
   endtask : do_reset

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      err_total = 0;
      checked = 0;
      foreach (t_aux[i]) t_aux[i] = 4'h0;
      foreach (t_dw[i]) t_dw[i] = 16'h0;
      // Chains end on 0 or 2 or at entry 255, speed-change stages carry no dwell
      t_aux[1] = 4'h1;
      t_aux[2] = 4'h3;
      t_aux[3] = 4'h2;
      t_aux[254] = 4'h3;
      t_aux[255] = 4'h1;
      t_aux[4] = 4'h1;
      t_aux[5] = 4'h8;
      t_aux[7] = 4'hB;
      t_aux[8] = 4'h9;
      t_dw[4] = 16'h1;
      t_dw[5] = 16'h1;
      t_dw[7] = 16'h1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("seg_entry", 8'h01, seg_entry);
      rd(OFS_INP_RANGE, 32'h64, '1);
      rd(OFS_IRQ_MASK, 32'h0, '1);
      rd(8'hFC, 32'h0, '1);
      chk("pslverr", 1'b1, slv);
      foreach (lst[i]) put(lst[i]);
      wr(OFS_ROUGH, 32'h32);
      wr(OFS_IRQ_STAT, 32'h7);
      wr(OFS_IRQ_MASK, 32'h1);
      run(8'd10, 1, 1'b0);
      finish_run(8'd10);
      @(negedge pclk);
      chk("irq", 1'b1, irq);
      wr(OFS_IRQ_STAT, 32'h1);
      @(negedge pclk);
      chk("irq", 1'b0, irq);
      run(8'd1, 3, 1'b0);
      finish_run(8'd3);
      run(8'd254, 2, 1'b0);
      finish_run(8'hFF);
      run(8'd7, 4, 1'b0);
      finish_run(8'd3);
      run(8'd8, 4, 1'b0);
      finish_run(8'd3);
      wr(OFS_IRQ_MASK, 32'h4);
      wr(OFS_IRQ_STAT, 32'h7);
      // Wide range lets the sequencer idle while the motor still settles
      wr(OFS_INP_RANGE, 32'h1F4);
      run(8'd10, 1, 1'b0);
      finish_run(8'd10);
      wr(OFS_CTRL, 32'h0000_0101);
      rd(OFS_IRQ_STAT, 32'h4, 32'h4);
      chk("irq", 1'b1, irq);
      chk("seg_entry", 8'd10, seg_entry);
      wr(OFS_INP_RANGE, 32'h64);
      wr(OFS_IRQ_STAT, 32'h7);
      run(8'd4, 5, 1'b1);
      t_aux[5] = 4'hA;
      do_reset();
      run(8'd4, 5, 1'b0);
      print_verdict();
   end
endmodule : tb_pts_sequencer

bind pts_sequencer pts_properties chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .motor_moving, .seg_done, .follow_err, .remain_dist, .seg_load, .seg_speed_change, .seg_target, .seg_entry,
   .in_position_flag, .travel_complete_flag);
